// *** hdl/ombe_pkg.sv ***
package ombe_pkg;
   // operation codes presented by the core's decoder
   localparam logic [3:0] OP_NONE      = 4'h0;
   localparam logic [3:0] OP_OR_FILE   = 4'h1;
   localparam logic [3:0] OP_OR_IMM    = 4'h2;
   localparam logic [3:0] OP_RD_PAGE   = 4'h3;
   localparam logic [3:0] OP_WR_PAGE   = 4'h4;
   localparam logic [3:0] OP_FAR_CALL  = 4'h5;
   localparam logic [3:0] OP_FAR_JUMP  = 4'h6;
   localparam logic [3:0] OP_LOAD_IMM  = 4'h7;
   // widths and ranges
   localparam int DATA_W     = 8;
   localparam int FILE_AW    = 7;
   localparam int PAGE_AW    = 4;
   localparam int PC_W       = 11;
   localparam int STACK_AW   = 3;
   localparam logic [3:0] PAGE_LO = 4'h5;
   localparam logic [3:0] PAGE_HI = 4'hf;
   // reset values
   localparam logic [7:0]  WORK_RST  = 8'h00;
   localparam logic [10:0] PC_RST    = 11'h000;
   localparam logic [2:0]  SP_RST    = 3'h1;
   localparam logic [7:0]  PAGE_RST  = 8'h00;
   // cycle counts
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   typedef enum logic [1:0] {
      OMBE_IDLE = 2'b00,
      OMBE_BUSY = 2'b01
   } ombe_state_t;
endpackage

// *** hdl/ombe_stack_mem.sv ***
`timescale 1ns/1ps
// return address store, registered read
module ombe_stack_mem
   import ombe_pkg::*;
#(
   parameter int AW = STACK_AW,
   parameter int DW = PC_W
) (
   input  wire logic          clock_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on storage; contents only meaningful once pushed
   always_ff @(posedge clock_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule

// *** hdl/ombe_core.sv ***
`timescale 1ns/1ps
// Summary of operation
// - or working with file, dest bit selects target
// - or immediate into working, one cycle
// - copy page register 5..15 to working
// - load page register 5..15 from working
// - far call pushes next address, loads pc
// - push at current level, then pointer increments
// - far jump loads 11-bit pc, two cycles
// - load immediate into working, flags unchanged
module ombe_core
   import ombe_pkg::*;
(
   input  wire logic               clock_i,
   input  wire logic               arst_n_i,
   input  wire logic               valid_i,
   input  wire logic [3:0]         op_i,
   input  wire logic [7:0]         imm_i,
   input  wire logic [PC_W-1:0]    target_i,
   input  wire logic [FILE_AW-1:0] file_addr_i,
   input  wire logic               dest_i,
   input  wire logic [PAGE_AW-1:0] page_idx_i,
   input  wire logic [7:0]         file_rdata_i,
   output logic                    ready_o,
   output logic                    done_o,
   output logic [7:0]              working_o,
   output logic                    zero_o,
   output logic [PC_W-1:0]         pc_o,
   output logic [STACK_AW-1:0]     sp_o,
   output logic                    file_we_o,
   output logic [FILE_AW-1:0]      file_waddr_o,
   output logic [7:0]              file_wdata_o,
   output logic [7:0]              page_rdata_o,
   output logic [PC_W-1:0]         stack_top_o
);
   // branch state, page file and shared decode
   ombe_state_t           state_r;
   logic [7:0]            page_r [PAGE_LO:PAGE_HI];
   logic [PC_W-1:0]       tgt_r;
   logic                  push_we;
   logic [PC_W-1:0]       ret_addr;
   logic [7:0]            or_res;
   logic                  accept;
   logic                  page_ok;
   logic                  take_far;
   logic                  take_or;
   logic                  take_single;
   logic [STACK_AW-1:0]   top_addr;

   // or result shared by both or forms
   function automatic logic [7:0] or_val(input logic [7:0] a, input logic [7:0] b);
      or_val = a | b;
   endfunction

   // index window of the second page; anything else is refused
   function automatic logic in_page(input logic [PAGE_AW-1:0] idx);
      in_page = (idx >= PAGE_LO) && (idx <= PAGE_HI);
   endfunction

   // two-cycle branch forms; they steal the following cycle
   function automatic logic is_far(input logic [3:0] op);
      is_far = (op == OP_FAR_CALL) || (op == OP_FAR_JUMP);
   endfunction

   // the only forms that touch the zero flag
   function automatic logic is_or(input logic [3:0] op);
      is_or = (op == OP_OR_FILE) || (op == OP_OR_IMM);
   endfunction

   // one-cycle forms that report completion; the idle code does not
   function automatic logic is_single(input logic [3:0] op);
      is_single = !is_far(op) && (op != OP_NONE);
   endfunction

   // take decode, shared by every register below
   assign accept      = valid_i && (state_r == OMBE_IDLE);
   assign take_far    = accept && is_far(op_i);
   assign take_or     = accept && is_or(op_i);
   assign take_single = accept && is_single(op_i);
   assign page_ok     = in_page(page_idx_i);
   assign or_res      = or_val(working_o, (op_i == OP_OR_FILE) ? file_rdata_i : imm_i);
   assign ret_addr    = PC_W'(pc_o + 1'b1);
   assign push_we     = accept && (op_i == OP_FAR_CALL);
   // last pushed entry sits one below the pointer
   assign top_addr    = STACK_AW'(sp_o - 1'b1);

   // two-cycle branches hold the second cycle here
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= OMBE_IDLE;
         tgt_r   <= PC_RST;
      end else begin
         case (state_r)
            OMBE_IDLE: begin
               if (take_far) begin
                  state_r <= OMBE_BUSY;
                  tgt_r   <= target_i;
               end
            end
            OMBE_BUSY: state_r <= OMBE_IDLE;
            default:   state_r <= OMBE_IDLE;
         endcase
      end
   end

   // ready drops for the second branch cycle; a request then is ignored
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ready_o <= 1'b1;
      end else begin
         ready_o <= !take_far;
      end
   end

   // done pulses once per instruction, at its last edge
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= take_single || (state_r == OMBE_BUSY);
      end
   end

   // working register
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         working_o <= WORK_RST;
      end else if (accept) begin
         case (op_i)
            OP_OR_FILE:  if (!dest_i) working_o <= or_res;
            OP_OR_IMM:   working_o <= or_res;
            OP_RD_PAGE:  if (page_ok) working_o <= page_r[page_idx_i];
            OP_LOAD_IMM: working_o <= imm_i;
            default:     working_o <= working_o;
         endcase
      end
   end

   // zero flag: only the or forms touch it
   // dest bit does not matter here, both or forms report
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         zero_o <= 1'b0;
      end else if (take_or) begin
         zero_o <= (or_res == 8'h00);
      end
   end

   // file write-back when dest bit is one
   // address and data load on every accepted or-file, for either dest bit; only the strobe needs dest one
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         file_we_o    <= 1'b0;
         file_waddr_o <= 7'h00;
         file_wdata_o <= 8'h00;
      end else begin
         file_we_o <= accept && (op_i == OP_OR_FILE) && dest_i;
         if (accept && (op_i == OP_OR_FILE)) begin
            file_waddr_o <= file_addr_i;
            file_wdata_o <= or_res;
         end
      end
   end

   // second-page registers; indices outside 5..15 are ignored
   // the working register is sampled as it stood before this edge
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = PAGE_LO; i <= PAGE_HI; i++) begin
            page_r[i] <= PAGE_RST;
         end
      end else if (accept && (op_i == OP_WR_PAGE) && page_ok) begin
         page_r[page_idx_i] <= working_o;
      end
   end

   // page read port mirrors the addressed entry
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         page_rdata_o <= PAGE_RST;
      end else begin
         page_rdata_o <= page_ok ? page_r[page_idx_i] : 8'h00;
      end
   end

   // program counter: target lands at end of second cycle
   // far forms first step to the return address, then to the target
   // the idle code leaves it alone so a stalled decoder does not run on
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_o <= PC_RST;
      end else if (state_r == OMBE_BUSY) begin
         pc_o <= tgt_r;
      end else if (accept && op_i != OP_NONE) begin
         pc_o <= ret_addr;
      end
   end

   // stack pointer; wraps silently, depth limits are the core's concern
   // pointer moves only on a call; a jump leaves the stack alone
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sp_o <= SP_RST;
      end else if (push_we) begin
         sp_o <= STACK_AW'(sp_o + 1'b1);
      end
   end

   // return address written at the current level before advancing
   // read port trails the pointer so stack_top_o shows the newest entry
   ombe_stack_mem #(
      .AW (STACK_AW),
      .DW (PC_W)
   ) u_stack (
      .clock_i (clock_i),
      .we_i    (push_we),
      .waddr_i (sp_o),
      .wdata_i (ret_addr),
      .raddr_i (top_addr),
      .rdata_o (stack_top_o)
   );
endmodule

// *** bench/ombe_core_assertions.sv ***
`timescale 1ns/1ps
module ombe_core_chk
   import ombe_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic        valid_i,
   input wire logic [3:0]  op_i,
   input wire logic [7:0]  imm_i,
   input wire logic [10:0] target_i,
   input wire logic        dest_i,
   input wire logic [7:0]  file_rdata_i,
   input wire logic        ready_o,
   input wire logic        done_o,
   input wire logic [7:0]  working_o,
   input wire logic        zero_o,
   input wire logic [10:0] pc_o,
   input wire logic [2:0]  sp_o,
   input wire logic        file_we_o,
   input wire logic [7:0]  file_wdata_o,
   input wire logic [3:0]  page_idx_i,
   input wire logic [10:0] stack_top_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // instruction accepted at this edge
   logic tk;
   assign tk = valid_i & ready_o;
   or_imm_a: assert property (tk && op_i == OP_OR_IMM |=>
      working_o == ($past(working_o) | $past(imm_i)) && zero_o == (working_o == 8'h00))
      else $error("or imm wrong");
   or_work_a: assert property (tk && op_i == OP_OR_FILE && !dest_i |=>
      working_o == ($past(working_o) | $past(file_rdata_i))) else $error("or work wrong");
   or_file_a: assert property (tk && op_i == OP_OR_FILE && dest_i |=>
      file_we_o && file_wdata_o == ($past(working_o) | $past(file_rdata_i))
      && $stable(working_o) && zero_o == (file_wdata_o == 8'h00)) else $error("or file wrong");
   load_imm_a: assert property (tk && op_i == OP_LOAD_IMM |=>
      working_o == $past(imm_i) && $stable(zero_o)) else $error("load imm wrong");
   page_rd_a: assert property (tk && op_i == OP_RD_PAGE |=>
      $stable(zero_o) && done_o) else $error("page read wrong");
   page_wr_a: assert property (tk && op_i == OP_WR_PAGE |=>
      $stable(zero_o) && $stable(working_o) && done_o) else $error("page write wrong");
   far_call_a: assert property (tk && op_i == OP_FAR_CALL |=>
      sp_o == $past(sp_o) + 3'h1 && !ready_o ##1 pc_o == $past(target_i, 2) && done_o)
      else $error("far call wrong");
   far_jump_a: assert property (tk && op_i == OP_FAR_JUMP |=>
      $stable(sp_o) && !done_o ##1 $stable(sp_o) && pc_o == $past(target_i, 2) && done_o)
      else $error("far jump wrong");
   page_out_a: assert property (tk && op_i == OP_RD_PAGE && page_idx_i < PAGE_LO |=>
      $stable(working_o)) else $error("page refuse wrong");
   stack_push_a: assert property (tk && op_i == OP_FAR_CALL |=>
      pc_o == $past(pc_o) + 11'h001 ##1 stack_top_o == $past(pc_o, 2) + 11'h001)
      else $error("stack push wrong");
endmodule
bind ombe_core ombe_core_chk chk_i (
   .clock_i      (clock_i),
   .arst_n_i     (arst_n_i),
   .valid_i      (valid_i),
   .op_i         (op_i),
   .imm_i        (imm_i),
   .target_i     (target_i),
   .dest_i       (dest_i),
   .file_rdata_i (file_rdata_i),
   .ready_o      (ready_o),
   .done_o       (done_o),
   .working_o    (working_o),
   .zero_o       (zero_o),
   .pc_o         (pc_o),
   .sp_o         (sp_o),
   .file_we_o    (file_we_o),
   .file_wdata_o (file_wdata_o),
   .page_idx_i   (page_idx_i),
   .stack_top_o  (stack_top_o)
);

// *** bench/ombe_core_bench.sv ***
`timescale 1ns/1ps
module ombe_core_bench
   import ombe_pkg::*;
;
   logic        clock_i, arst_n_i, valid_i, dest_i, ready_o, done_o, zero_o, file_we_o;
   logic [3:0]  op_i, page_idx_i;
   logic [7:0]  imm_i, file_rdata_i, working_o, file_wdata_o, page_rdata_o;
   logic [6:0]  file_addr_i, file_waddr_o;
   logic [10:0] target_i, pc_o, stack_top_o;
   logic [2:0]  sp_o;
   int          n_fail, samples_checked;
   ombe_core dut (
      .clock_i      (clock_i),
      .arst_n_i     (arst_n_i),
      .valid_i      (valid_i),
      .op_i         (op_i),
      .imm_i        (imm_i),
      .target_i     (target_i),
      .file_addr_i  (file_addr_i),
      .dest_i       (dest_i),
      .page_idx_i   (page_idx_i),
      .file_rdata_i (file_rdata_i),
      .ready_o      (ready_o),
      .done_o       (done_o),
      .working_o    (working_o),
      .zero_o       (zero_o),
      .pc_o         (pc_o),
      .sp_o         (sp_o),
      .file_we_o    (file_we_o),
      .file_waddr_o (file_waddr_o),
      .file_wdata_o (file_wdata_o),
      .page_rdata_o (page_rdata_o),
      .stack_top_o  (stack_top_o)
   );
   // 25 ns period
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   task chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // one request; a gap cycle between calls keeps far ops legal
   task iss(input logic [3:0] op, input logic [7:0] d);
      @(posedge clock_i) #2;
      op_i = op;
      imm_i = d;
      valid_i = 1'b1;
      @(posedge clock_i) #2;
      valid_i = 1'b0;
   endtask
   task t_imm;
      iss(OP_LOAD_IMM, 8'haa);
      chk("work", 11'(working_o), 11'h0aa);
      chk("done", 11'(done_o), 11'h001);
      iss(OP_OR_IMM, 8'h50);
      chk("work", 11'(working_o), 11'h0fa);
      iss(OP_LOAD_IMM, 8'h00);
      iss(OP_OR_IMM, 8'h00);
      chk("zero", 11'(zero_o), 11'h001);
      iss(OP_LOAD_IMM, 8'h33);
      chk("zero", 11'(zero_o), 11'h001);
   endtask
   // file address at the top of the range
   task t_file;
      file_rdata_i = 8'h50;
      file_addr_i = 7'h7f;
      dest_i = 1'b1;
      iss(OP_LOAD_IMM, 8'haa);
      iss(OP_OR_FILE, 8'h00);
      chk("fdat", 11'(file_wdata_o), 11'h0fa);
      chk("fadr", 11'(file_waddr_o), 11'h07f);
      chk("fwe", 11'(file_we_o), 11'h001);
      chk("work", 11'(working_o), 11'h0aa);
      chk("zero", 11'(zero_o), 11'h000);
      dest_i = 1'b0;
      iss(OP_OR_FILE, 8'h00);
      chk("work", 11'(working_o), 11'h0fa);
   endtask
   // index 4 is outside the page and must leave working alone
   task t_page;
      page_idx_i = 4'h5;
      iss(OP_LOAD_IMM, 8'h55);
      iss(OP_WR_PAGE, 8'h00);
      iss(OP_LOAD_IMM, 8'h00);
      iss(OP_RD_PAGE, 8'h00);
      chk("work", 11'(working_o), 11'h055);
      chk("prd", 11'(page_rdata_o), 11'h055);
      page_idx_i = 4'h4;
      iss(OP_RD_PAGE, 8'h00);
      chk("work", 11'(working_o), 11'h055);
      chk("prd", 11'(page_rdata_o), 11'h000);
      page_idx_i = 4'hf;
      iss(OP_RD_PAGE, 8'h00);
      chk("work", 11'(working_o), 11'h000);
      chk("zero", 11'(zero_o), 11'h000);
   endtask
   // fourteen instructions so far; the idle code must not advance pc
   task t_far;
      iss(OP_NONE, 8'h00);
      chk("pc", pc_o, 11'h00e);
      target_i = 11'h123;
      iss(OP_FAR_JUMP, 8'h00);
      @(posedge clock_i) #2;
      chk("pc", pc_o, 11'h123);
      chk("sp", 11'(sp_o), 11'h001);
      target_i = 11'h7ff;
      iss(OP_FAR_CALL, 8'h00);
      chk("pc", pc_o, 11'h124);
      chk("sp", 11'(sp_o), 11'h002);
      chk("rdy", 11'(ready_o), 11'h000);
      chk("done", 11'(done_o), 11'h000);
      @(posedge clock_i) #2;
      chk("pc", pc_o, 11'h7ff);
      chk("done", 11'(done_o), 11'h001);
      chk("top", stack_top_o, 11'h124);
   endtask
   task close_out;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      arst_n_i = 1'b0;
      valid_i = 1'b0;
      op_i = OP_NONE;
      imm_i = 8'h00;
      target_i = 11'h000;
      file_addr_i = 7'h00;
      dest_i = 1'b0;
      page_idx_i = 4'h5;
      file_rdata_i = 8'h00;
      repeat (12) @(posedge clock_i);
      #2 arst_n_i = 1'b1;
      t_imm;
      t_file;
      t_page;
      t_far;
      close_out;
   end
endmodule
